//--- rtl/ddec_pkg.sv
/*
 Shared constants and types of the decimal instruction decoder: two-digit
 operation codes, output unit codes, typewriter functions, fixed execution times
 in microseconds, formula terms in quarter microseconds, and the structs that carry an instruction,
 its operand facts, the decoded result and the decoder state.
 Assumes a 100 MHz core clock; all times are counted in quarter microseconds.
*/
package ddec_pkg;

   // Clock and time base
   localparam int CLK_MHZ     = 100;
   localparam int QUS_PER_US  = 4;
   localparam int TICK_CYCLES = CLK_MHZ / QUS_PER_US;

   // Operation codes, two BCD digits
   localparam logic [7:0] OPC_FLOAT_ADD = 8'h01, OPC_FLOAT_SUB = 8'h02, OPC_FLOAT_MUL = 8'h03;
   localparam logic [7:0] OPC_FLOAT_SHL = 8'h05, OPC_FLOAT_SHR = 8'h08, OPC_FLOAT_DIV = 8'h09;
   localparam logic [7:0] OPC_MUL_LIT   = 8'h13, OPC_CMP_IMM   = 8'h14, OPC_LDIV_LIT  = 8'h18;
   localparam logic [7:0] OPC_DIV_IMM   = 8'h19, OPC_MUL       = 8'h23, OPC_CMP       = 8'h24;
   localparam logic [7:0] OPC_LDIV      = 8'h28, OPC_DIV       = 8'h29, OPC_CLR_FLAG  = 8'h33;
   localparam logic [7:0] OPC_CONTROL   = 8'h34, OPC_DUMP_NUM  = 8'h35, OPC_NOOP      = 8'h41;
   localparam logic [7:0] OPC_HALT      = 8'h48, OPC_MOVE_ADDR = 8'h70, OPC_MOVE_FLAG = 8'h71;
   localparam logic [7:0] OPC_OR_FIELD  = 8'h92, OPC_CPL_OCT   = 8'h94, OPC_XOR_FIELD = 8'h95;
   localparam logic [7:0] OPC_OCT_DEC   = 8'h96, OPC_DEC_OCT   = 8'h97;

   // Unit codes in instruction digits 8-9, typewriter functions in digit 11
   localparam logic [7:0] UNIT_TYPEWRITER = 8'h01, UNIT_TAPE_PLOT = 8'h02;
   localparam logic [7:0] UNIT_CARD = 8'h04, UNIT_PRINTER = 8'h09;
   localparam logic [3:0] TYF_SPACE = 4'h1, TYF_RETURN = 4'h2, TYF_BACK = 4'h3;
   localparam logic [3:0] TYF_INDEX = 4'h4, TYF_TAB = 4'h8;

   // Fixed times in microseconds
   localparam int T_CLR_FLAG_US = 70, T_MOVE_FLAG_US = 80, T_MOVE_ADDR_US = 140, T_HALT_NOP_US = 60;

   // Formula terms in quarter microseconds (four times each printed term)
   localparam int Q_CMPU_BASE = 320, Q_CMPU_DZ = 60;
   localparam int Q_CMPL_BASE = 260, Q_CMPL_DQ = 20, Q_CMPL_DP = 40;
   localparam int Q_LOGIC_BASE = 240, Q_LOGIC_DQ = 80;
   localparam int Q_DTO_BASE = 1240, Q_DTO_TQ = 40, Q_DTO_TQ2 = 165;
   localparam int Q_DIV_BASE = 240, Q_DIV_QT = 540, Q_DIV_DVQT = 390;
   localparam int Q_FLOAT_ADD_BASE = 600, Q_FLOAT_ADD_L = 88, Q_RECOMP_L = 40;
   localparam int Q_FLOAT_DIVIDE_BASE = 1380, Q_FLOAT_DIVIDE_L = 1080, Q_FLOAT_DIVIDE_L2 = 390;
   localparam int Q_FLOAT_MULTIPLY_BASE = 1120, Q_FLOAT_MULTIPLY_L = 120, Q_MUL_LZ = 160, Q_MUL_PROD = 160;
   localparam int Q_FSH_BASE = 280, Q_FSH_L = 80;
   localparam int Q_LD_BASE = 700, Q_LD_DN = 60;
   localparam int Q_MUL_BASE = 640, Q_MUL_DQ = 40;
   localparam int Q_OTD_BASE = 1120, Q_OTD_DQ = 40;
   localparam int Q_MIN = 1;

   typedef enum logic [4:0] {
      OP_ILLEGAL = 5'b00000, OP_FLOAT_ADD = 5'b00001, OP_FLOAT_SUB = 5'b00010, OP_FLOAT_MUL = 5'b00011,
      OP_FLOAT_SHL = 5'b00100, OP_FLOAT_SHR = 5'b00101, OP_FLOAT_DIV = 5'b00110, OP_MULTIPLY = 5'b00111,
      OP_COMPARE = 5'b01000, OP_LOAD_DIV = 5'b01001, OP_DIVIDE = 5'b01010, OP_CLR_FLAG = 5'b01011,
      OP_CONTROL = 5'b01100, OP_DUMP_NUM = 5'b01101, OP_NOOP = 5'b01110, OP_HALT = 5'b01111,
      OP_MOVE_ADDR = 5'b10000, OP_MOVE_FLAG = 5'b10001, OP_OR_FIELD = 5'b10010, OP_CPL_OCT = 5'b10011,
      OP_XOR_FIELD = 5'b10100, OP_OCT_DEC = 5'b10101, OP_DEC_OCT = 5'b10110
   } ddec_op_t;

   typedef enum logic [2:0] {
      PR_NONE = 3'b000, PR_UNITS = 3'b001, PR_FLAG = 3'b010, PR_HIGH_ORDER = 3'b011,
      PR_EXPONENT = 3'b100, PR_PRODUCT = 3'b101, PR_TABLE = 3'b110, PR_FIRST_CHAR = 3'b111
   } ddec_prole_t;

   typedef enum logic [2:0] {
      QR_NONE = 3'b000, QR_UNITS = 3'b001, QR_IMMEDIATE = 3'b010, QR_FLAG = 3'b011,
      QR_EXPONENT = 3'b100, QR_POW8 = 3'b101, QR_UNIT_SEL = 3'b110
   } ddec_qrole_t;

   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} ddec_state_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] unit;
      logic [3:0] q10;
      logic [3:0] func;
      logic       p_flag;
      logic       q_flag;
   } ddec_instr_t;

   typedef struct packed {
      logic [7:0] dq, dp, dz, l, lz, lgain, tq, qt, dv, dn, chars;
      logic       signs_unlike;
      logic       q_gt_p;
   } ddec_facts_t;

   typedef struct packed {
      ddec_op_t    op;
      ddec_prole_t p_role;
      ddec_qrole_t q_role;
      logic        q_immediate;
      logic        p_indirect;
      logic        q_indirect;
      logic        recomp;
      logic        interlock_only;
      logic        illegal;
      logic [7:0]  unit;
      logic [3:0]  func;
   } ddec_decode_t;

   typedef struct packed {
      ddec_state_t  state;
      ddec_decode_t dec;
      logic [31:0]  rem_qus;
      logic [15:0]  pre;
      logic [31:0]  time_qus;
      logic [31:0]  motion_qus;
      logic [31:0]  tail_qus;
      logic [15:0]  tail_pre;
      logic         halted;
      logic         done;
   } ddec_regs_t;

endpackage

//--- rtl/ddec_decoder.sv
/*
 Decimal instruction decoder and execution timer. Takes one instruction at a
 time, decodes how its P and Q addresses are used, and holds the processor
 interlocked for the documented execution time.
 Assumes operand lengths and sign facts come from the storage sequencer with
 the instruction, and that all inputs are synchronous to CORE_CLK.
*/
`timescale 1ns/1ps

module ddec_decoder
   import ddec_pkg::*;
#(
   parameter int TICK                = TICK_CYCLES,
   parameter int TYPE_SHORT_MS       = 56,
   parameter int TYPE_RETURN_MS      = 124,
   parameter int TYPE_RETURN_TOTAL_MS = 800,
   parameter int TYPE_TAB_TOTAL_MS   = 250,
   parameter int CARD_OUT_US         = 1700,
   parameter int PRINTER_OUT_US      = 2100,
   parameter int PLOTTER_OUT_US      = 200,
   parameter int TYPE_CHAR_US        = 64516,
   parameter int PRINTER_CTRL_US     = 2100
) (
   input  wire logic         CORE_CLK,
   input  wire logic         RESET,
   input  wire logic         CLK_EN,
   input  wire logic         INSTR_VALID,
   input  wire ddec_instr_t  INSTR,
   input  wire ddec_facts_t  FACTS,
   input  wire logic         INDIRECT_ON,
   input  wire logic         OPER_RESTART,
   output      logic         INSTR_READY,
   output      ddec_decode_t DECODE,
   output      logic         EXEC_BUSY,
   output      logic         EXEC_DONE,
   output      logic [31:0]  EXEC_QUS,
   output      logic         HALTED,
   output      logic         TYPE_BUSY
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode of operation code and address roles

   function automatic ddec_decode_t decode_op(input ddec_instr_t i, input logic ind_on);
      ddec_decode_t d;
      logic         p_ok;
      logic         q_ok;
      d = '0;
      d.op = OP_ILLEGAL;
      d.unit = i.unit;
      d.func = i.func;
      p_ok = 1'b1;
      q_ok = 1'b1;
      case (i.opcode)
         OPC_CLR_FLAG: begin
            d.op = OP_CLR_FLAG;
            d.p_role = PR_FLAG;
            q_ok = 1'b0;
         end
         OPC_CMP, OPC_CMP_IMM: begin
            d.op = OP_COMPARE;
            d.p_role = PR_UNITS;
            d.q_role = (i.opcode == OPC_CMP_IMM) ? QR_IMMEDIATE : QR_UNITS;
            d.q_immediate = (i.opcode == OPC_CMP_IMM);
            q_ok = (i.opcode == OPC_CMP);
         end
         OPC_OR_FIELD, OPC_CPL_OCT, OPC_XOR_FIELD: begin
            d.op = (i.opcode == OPC_OR_FIELD) ? OP_OR_FIELD :
                   (i.opcode == OPC_CPL_OCT) ? OP_CPL_OCT : OP_XOR_FIELD;
            d.p_role = PR_UNITS;
            d.q_role = QR_UNITS;
         end
         OPC_DEC_OCT: begin
            d.op = OP_DEC_OCT;
            d.p_role = PR_HIGH_ORDER;
            d.q_role = QR_POW8;
         end
         OPC_DIV, OPC_DIV_IMM: begin
            d.op = OP_DIVIDE;
            d.p_role = PR_PRODUCT;
            d.q_role = (i.opcode == OPC_DIV_IMM) ? QR_IMMEDIATE : QR_UNITS;
            d.q_immediate = (i.opcode == OPC_DIV_IMM);
            q_ok = (i.opcode == OPC_DIV);
         end
         OPC_LDIV, OPC_LDIV_LIT: begin
            d.op = OP_LOAD_DIV;
            d.p_role = PR_PRODUCT;
            d.q_role = (i.opcode == OPC_LDIV_LIT) ? QR_IMMEDIATE : QR_UNITS;
            d.q_immediate = (i.opcode == OPC_LDIV_LIT);
            q_ok = (i.opcode == OPC_LDIV);
         end
         OPC_DUMP_NUM: begin
            d.op = OP_DUMP_NUM;
            d.p_role = PR_FIRST_CHAR;
            d.q_role = QR_UNIT_SEL;
            d.interlock_only = 1'b1;
            q_ok = 1'b0;
         end
         OPC_CONTROL: begin
            d.op = OP_CONTROL;
            d.q_role = QR_UNIT_SEL;
            d.interlock_only = (i.unit == UNIT_TYPEWRITER) && (i.func == TYF_RETURN || i.func == TYF_TAB);
            p_ok = 1'b0;
            q_ok = 1'b0;
         end
         OPC_FLOAT_ADD, OPC_FLOAT_SUB, OPC_FLOAT_DIV, OPC_FLOAT_MUL: begin
            d.op = (i.opcode == OPC_FLOAT_ADD) ? OP_FLOAT_ADD :
                   (i.opcode == OPC_FLOAT_SUB) ? OP_FLOAT_SUB :
                   (i.opcode == OPC_FLOAT_DIV) ? OP_FLOAT_DIV : OP_FLOAT_MUL;
            d.p_role = PR_EXPONENT;
            d.q_role = QR_EXPONENT;
         end
         OPC_FLOAT_SHL: begin
            d.op = OP_FLOAT_SHL;
            d.p_role = PR_HIGH_ORDER;
            d.q_role = QR_UNITS;
         end
         OPC_FLOAT_SHR: begin
            d.op = OP_FLOAT_SHR;
            d.p_role = PR_UNITS;
            d.q_role = QR_UNITS;
         end
         OPC_MOVE_ADDR: begin
            d.op = OP_MOVE_ADDR;
            d.p_role = PR_UNITS;
            d.q_role = QR_UNITS;
         end
         OPC_MOVE_FLAG: begin
            d.op = OP_MOVE_FLAG;
            d.p_role = PR_FLAG;
            d.q_role = QR_FLAG;
         end
         OPC_MUL, OPC_MUL_LIT: begin
            d.op = OP_MULTIPLY;
            d.p_role = PR_UNITS;
            d.q_role = (i.opcode == OPC_MUL_LIT) ? QR_IMMEDIATE : QR_UNITS;
            d.q_immediate = (i.opcode == OPC_MUL_LIT);
            q_ok = (i.opcode == OPC_MUL);
         end
         OPC_OCT_DEC: begin
            d.op = OP_OCT_DEC;
            d.p_role = PR_TABLE;
            d.q_role = QR_UNITS;
         end
         OPC_HALT, OPC_NOOP: begin
            d.op = (i.opcode == OPC_HALT) ? OP_HALT : OP_NOOP;
            p_ok = 1'b0;
            q_ok = 1'b0;
         end
         default: begin
            d.illegal = 1'b1;
            p_ok = 1'b0;
            q_ok = 1'b0;
         end
      endcase
      // Indirect resolution only where the operand allows it
      d.p_indirect = ind_on && i.p_flag && p_ok;
      d.q_indirect = ind_on && i.q_flag && q_ok;
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Execution time in quarter microseconds; [63:32] interlock, [31:0] total

   function automatic logic [63:0] exec_time(input ddec_decode_t d, input ddec_facts_t f);
      logic [31:0] il;
      logic [31:0] tot;
      logic [31:0] live;
      il = 32'(Q_MIN);
      live = (f.lz > f.l) ? 32'd0 : 32'(f.l - f.lz);
      case (d.op)
         OP_CLR_FLAG:  il = 32'(T_CLR_FLAG_US * QUS_PER_US);
         OP_COMPARE:   il = f.signs_unlike ? 32'(Q_CMPU_BASE + Q_CMPU_DZ * int'(f.dz))
                                           : 32'(Q_CMPL_BASE + Q_CMPL_DQ * int'(f.dq) + Q_CMPL_DP * int'(f.dp));
         OP_OR_FIELD, OP_CPL_OCT, OP_XOR_FIELD:
                       il = 32'(Q_LOGIC_BASE + Q_LOGIC_DQ * int'(f.dq));
         OP_DEC_OCT:   il = 32'(Q_DTO_BASE + Q_DTO_TQ * int'(f.tq) + Q_DTO_TQ2 * int'(f.tq) * (int'(f.tq) + 1));
         OP_DIVIDE:    il = 32'(Q_DIV_BASE + Q_DIV_QT * int'(f.qt) + Q_DIV_DVQT * int'(f.dv) * int'(f.qt));
         OP_LOAD_DIV:  il = 32'(Q_LD_BASE + Q_LD_DN * int'(f.dn));
         OP_FLOAT_ADD, OP_FLOAT_SUB:
                       il = 32'(Q_FLOAT_ADD_BASE + Q_FLOAT_ADD_L * int'(f.l)) +
                            (d.recomp ? 32'(Q_RECOMP_L * int'(f.l)) : 32'd0);
         OP_FLOAT_DIV: il = 32'(Q_FLOAT_DIVIDE_BASE + Q_FLOAT_DIVIDE_L * int'(f.l) + Q_FLOAT_DIVIDE_L2 * int'(f.l) * int'(f.l));
         OP_FLOAT_MUL: il = 32'(Q_FLOAT_MULTIPLY_BASE + Q_FLOAT_MULTIPLY_L * int'(f.l) + Q_MUL_LZ * int'(f.lz)
                            + Q_MUL_PROD * int'(f.l) * int'(live));
         OP_FLOAT_SHL: il = 32'(Q_FSH_BASE + Q_FSH_L * int'(f.l) + Q_FSH_L * int'(f.lgain));
         OP_FLOAT_SHR: il = 32'(Q_FSH_BASE + Q_FSH_L * int'(f.l));
         OP_MULTIPLY:  il = 32'(Q_MUL_BASE + Q_MUL_DQ * int'(f.dq) + Q_MUL_LZ * int'(f.lz)
                            + Q_MUL_PROD * int'(f.dp) * ((f.lz > f.dq) ? 0 : int'(f.dq) - int'(f.lz)));
         OP_OCT_DEC:   il = 32'(Q_OTD_BASE + Q_OTD_DQ * int'(f.dq) * (2 * int'(f.dq) - 1));
         OP_MOVE_ADDR: il = 32'(T_MOVE_ADDR_US * QUS_PER_US);
         OP_MOVE_FLAG: il = 32'(T_MOVE_FLAG_US * QUS_PER_US);
         OP_HALT, OP_NOOP: il = 32'(T_HALT_NOP_US * QUS_PER_US);
         OP_DUMP_NUM: begin
            case (d.unit)
               UNIT_CARD:       il = 32'(CARD_OUT_US * QUS_PER_US);
               UNIT_PRINTER:    il = 32'(PRINTER_OUT_US * QUS_PER_US);
               UNIT_TAPE_PLOT:  il = 32'(PLOTTER_OUT_US * QUS_PER_US);
               UNIT_TYPEWRITER: il = 32'(TYPE_CHAR_US * QUS_PER_US) * 32'(f.chars);
               default:         il = 32'(Q_MIN);
            endcase
         end
         OP_CONTROL: begin
            if (d.unit == UNIT_TYPEWRITER) begin
               il = (d.func == TYF_RETURN || d.func == TYF_INDEX) ? 32'(TYPE_RETURN_MS * 1000 * QUS_PER_US)
                                                                  : 32'(TYPE_SHORT_MS * 1000 * QUS_PER_US);
            end else begin
               il = 32'(PRINTER_CTRL_US * QUS_PER_US);
            end
         end
         default:      il = 32'(Q_MIN);
      endcase
      tot = il;
      if (d.op == OP_CONTROL && d.unit == UNIT_TYPEWRITER && d.func == TYF_RETURN) begin
         tot = 32'(TYPE_RETURN_TOTAL_MS * 1000 * QUS_PER_US);
      end
      if (d.op == OP_CONTROL && d.unit == UNIT_TYPEWRITER && d.func == TYF_TAB) begin
         tot = 32'(TYPE_TAB_TOTAL_MS * 1000 * QUS_PER_US);
      end
      if (il == 32'd0) begin
         il = 32'(Q_MIN);
      end
      return {il, tot};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing

   ddec_regs_t   r_reg;
   ddec_regs_t   r_next;
   ddec_decode_t dec_in;
   logic [63:0]  times;
   logic         uses_type;
   logic         accept;

   // Decode is combinational on the offered instruction; only latched on accept
   always_comb begin
      dec_in = decode_op(INSTR, INDIRECT_ON);
      dec_in.recomp = ((INSTR.opcode == OPC_FLOAT_SUB) && !FACTS.signs_unlike && FACTS.q_gt_p) ||
                      ((INSTR.opcode == OPC_FLOAT_ADD) && FACTS.signs_unlike && FACTS.q_gt_p);
      times = exec_time(dec_in, FACTS);
      // A typewriter op waits while the carriage is still moving
      uses_type = (INSTR.opcode == OPC_CONTROL || INSTR.opcode == OPC_DUMP_NUM) && INSTR.unit == UNIT_TYPEWRITER;
      INSTR_READY = (r_reg.state == ST_IDLE) && !r_reg.halted && !(uses_type && r_reg.tail_qus != 32'd0);
      accept = INSTR_VALID && INSTR_READY && CLK_EN;
   end

   // Next state: interlock timer, halt latch and trailing motion timer
   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (OPER_RESTART) begin
         r_next.halted = 1'b0;
      end
      case (r_reg.state)
         ST_IDLE: begin
            if (accept) begin
               r_next.state = ST_EXEC;
               r_next.dec = dec_in;
               r_next.rem_qus = times[63:32];
               r_next.time_qus = times[63:32];
               r_next.motion_qus = times[31:0] - times[63:32];
               r_next.pre = 16'h0000;
            end
         end
         ST_EXEC: begin
            if (r_reg.pre == 16'(TICK - 1)) begin
               r_next.pre = 16'h0000;
               if (r_reg.rem_qus == 32'h0000_0001) begin
                  r_next.state = ST_IDLE;
                  r_next.done = 1'b1;
                  r_next.halted = (r_reg.dec.op == OP_HALT);
                  if (r_reg.motion_qus != 32'd0) begin
                     r_next.tail_qus = r_reg.motion_qus;
                     r_next.tail_pre = 16'h0000;
                  end
               end else begin
                  r_next.rem_qus = r_reg.rem_qus - 32'h0000_0001;
               end
            end else begin
               r_next.pre = r_reg.pre + 16'h0001;
            end
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase
      // Carriage keeps moving after the processor is released
      if (r_reg.tail_qus != 32'd0 && !(r_next.done && r_reg.motion_qus != 32'd0)) begin
         if (r_reg.tail_pre == 16'(TICK - 1)) begin
            r_next.tail_pre = 16'h0000;
            r_next.tail_qus = r_reg.tail_qus - 32'h0000_0001;
         end else begin
            r_next.tail_pre = r_reg.tail_pre + 16'h0001;
         end
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         r_reg <= '0;
      end else if (CLK_EN) begin
         r_reg <= r_next;
      end
   end

   assign DECODE    = r_reg.dec;
   assign EXEC_BUSY = (r_reg.state == ST_EXEC);
   assign EXEC_DONE = r_reg.done;
   assign EXEC_QUS  = r_reg.time_qus;
   assign HALTED    = r_reg.halted;
   assign TYPE_BUSY = (r_reg.tail_qus != 32'd0);

endmodule

//--- dv/ddec_store_model.sv
/* Core storage stand-in: reports the operand field facts that go with each instruction.
   Assumes every operand field has the same length and holds no zero digits. */
`timescale 1ns/1ps
module ddec_store_model
   import ddec_pkg::*;
(
   input  wire logic [7:0]  field_len,
   input  wire logic        unlike,
   input  wire logic        q_above,
   output      ddec_facts_t facts
);
   // One length for every field keeps the expected times easy to derive;
   // zero counts stay 0, so no test or property exercises the zero-digit shortcut
   assign facts = '{dq: field_len, dp: field_len, dz: field_len, l: field_len, lz: 8'h00,
                    lgain: 8'h00, tq: field_len, qt: field_len, dv: field_len, dn: field_len,
                    chars: 8'h01, signs_unlike: unlike, q_gt_p: q_above};
endmodule

//--- dv/ddec_decoder_properties.sv
/* Decode and interlock properties of the decimal decoder.
   Assumes it is bound to the decoder and sees only its ports. */
`timescale 1ns/1ps
module ddec_decoder_properties
   import ddec_pkg::*;
(
   input wire logic         CORE_CLK,
   input wire logic         RESET,
   input wire logic         CLK_EN,
   input wire logic         INSTR_VALID,
   input wire ddec_instr_t  INSTR,
   input wire ddec_facts_t  FACTS,
   input wire logic         INDIRECT_ON,
   input wire logic         OPER_RESTART,
   input wire logic         INSTR_READY,
   input wire ddec_decode_t DECODE,
   input wire logic         EXEC_BUSY,
   input wire logic         EXEC_DONE,
   input wire logic [31:0]  EXEC_QUS,
   input wire logic         HALTED,
   input wire logic         TYPE_BUSY
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////////////
   // Accept strobe as the decoder sees it
   wire take = INSTR_VALID && INSTR_READY && CLK_EN;
   ////////////////////////////////////////////////////////////////////////////////
   // Interlock and decode relations
   busy_blocks_take_a: assert property (EXEC_BUSY |-> !INSTR_READY) else $error("ready while busy");
   take_starts_a: assert property (take |=> EXEC_BUSY || EXEC_DONE) else $error("no interlock");
   done_ends_busy_a: assert property (EXEC_DONE |-> !EXEC_BUSY && $past(EXEC_BUSY || take))
      else $error("stray done");
   clear_flag_time_a: assert property (take && INSTR.opcode == OPC_CLR_FLAG |=>
      EXEC_QUS == 32'h118 && DECODE.q_role == QR_NONE) else $error("clear flag decode");
   move_addr_time_a: assert property (take && INSTR.opcode == OPC_MOVE_ADDR |=>
      EXEC_QUS == 32'h230 && DECODE.op == OP_MOVE_ADDR) else $error("move address decode");
   move_flag_time_a: assert property (take && INSTR.opcode == OPC_MOVE_FLAG |=>
      EXEC_QUS == 32'h140 && DECODE.q_role == QR_FLAG) else $error("move flag decode");
   or_field_time_a: assert property (take && INSTR.opcode == OPC_OR_FIELD |=>
      EXEC_QUS == 32'hf0 + 32'h50 * $past(FACTS.dq)) else $error("or field time");
   imm_no_indirect_a: assert property (take && INSTR.opcode == OPC_CMP_IMM |=>
      DECODE.q_immediate && !DECODE.q_indirect) else $error("immediate went indirect");
   halt_sets_stop_a: assert property (EXEC_DONE && DECODE.op == OP_HALT |-> HALTED)
      else $error("halt did not stop");
   halt_holds_a: assert property (HALTED && !OPER_RESTART |-> !INSTR_READY ##1 HALTED)
      else $error("halt released early");
   type_wait_a: assert property (TYPE_BUSY && INSTR.opcode == OPC_CONTROL && INSTR.unit == UNIT_TYPEWRITER
      |-> !INSTR_READY) else $error("typewriter op taken in motion");
   enable_freezes_a: assert property (!CLK_EN |=> $stable(EXEC_BUSY) && $stable(EXEC_QUS) && $stable(HALTED))
      else $error("state moved while enable low");
endmodule
bind ddec_decoder ddec_decoder_properties u_props (.CORE_CLK, .RESET, .CLK_EN, .INSTR_VALID, .INSTR, .FACTS,
   .INDIRECT_ON, .OPER_RESTART, .INSTR_READY, .DECODE, .EXEC_BUSY, .EXEC_DONE, .EXEC_QUS, .HALTED, .TYPE_BUSY);

//--- dv/tb_top.sv
/* Self-checking bench of the decimal decoder: opcode table, then halt and typewriter cases.
   Assumes one cycle per quarter microsecond and shortened device times. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module tb_top;
   import ddec_pkg::*;
   typedef struct packed {logic [7:0] opc; logic un; logic qg; ddec_op_t op; logic [31:0] qus;} ddec_row_t;
   logic         core_clk = 1'b0, reset = 1'b1, valid = 1'b0, restart = 1'b0, unlike = 1'b0, q_above = 1'b0;
   logic         clk_en = 1'b1, ind_on = 1'b1;
   logic [7:0]   flen = 8'h02;
   ddec_instr_t  instr = '0;
   ddec_facts_t  facts;
   ddec_decode_t dec;
   logic         ready, busy, done, halted, type_busy;
   logic [31:0]  qus;
   int           errors = 0, checked = 0, cycles = 0, n = 0;
   ddec_row_t    rows [24] = '{'{8'h33,1'b0,1'b0,OP_CLR_FLAG,32'h118}, '{8'h24,1'b0,1'b0,OP_COMPARE,32'h17c},
      '{8'h24,1'b1,1'b0,OP_COMPARE,32'h1b8}, '{8'h14,1'b0,1'b0,OP_COMPARE,32'h17c},
      '{8'h92,1'b0,1'b0,OP_OR_FIELD,32'h190}, '{8'h94,1'b0,1'b0,OP_CPL_OCT,32'h190},
      '{8'h95,1'b0,1'b0,OP_XOR_FIELD,32'h190}, '{8'h97,1'b0,1'b0,OP_DEC_OCT,32'h906},
      '{8'h29,1'b0,1'b0,OP_DIVIDE,32'hb40}, '{8'h19,1'b0,1'b0,OP_DIVIDE,32'hb40},
      '{8'h28,1'b0,1'b0,OP_LOAD_DIV,32'h334}, '{8'h01,1'b0,1'b0,OP_FLOAT_ADD,32'h308},
      '{8'h02,1'b0,1'b1,OP_FLOAT_SUB,32'h358}, '{8'h09,1'b0,1'b0,OP_FLOAT_DIV,32'h13ec},
      '{8'h03,1'b0,1'b0,OP_FLOAT_MUL,32'h7d0}, '{8'h05,1'b0,1'b0,OP_FLOAT_SHL,32'h1b8},
      '{8'h08,1'b0,1'b0,OP_FLOAT_SHR,32'h1b8}, '{8'h13,1'b0,1'b0,OP_MULTIPLY,32'h550},
      '{8'h96,1'b0,1'b0,OP_OCT_DEC,32'h550}, '{8'h70,1'b0,1'b0,OP_MOVE_ADDR,32'h230},
      '{8'h71,1'b0,1'b0,OP_MOVE_FLAG,32'h140}, '{8'h41,1'b0,1'b0,OP_NOOP,32'hf0},
      '{8'h35,1'b0,1'b0,OP_DUMP_NUM,32'h28}, '{8'h99,1'b0,1'b0,OP_ILLEGAL,32'h1}};
   ////////////////////////////////////////////////////////////////////////////////
   // Storage model and decoder; short device times keep the run brief
   ddec_store_model u_store (.field_len(flen), .unlike(unlike), .q_above(q_above), .facts(facts));
   ddec_decoder #(.TICK(1), .TYPE_RETURN_MS(1), .TYPE_RETURN_TOTAL_MS(2), .PRINTER_OUT_US(10)) u_dut (
      .CORE_CLK(core_clk), .RESET(reset), .CLK_EN(clk_en), .INSTR_VALID(valid), .INSTR(instr), .FACTS(facts),
      .INDIRECT_ON(ind_on), .OPER_RESTART(restart), .INSTR_READY(ready), .DECODE(dec), .EXEC_BUSY(busy),
      .EXEC_DONE(done), .EXEC_QUS(qus), .HALTED(halted), .TYPE_BUSY(type_busy));
   // 100 MHz clock
   always #5 core_clk = ~core_clk;
   // Hang guard; the whole sequence needs about 34500 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Offer one instruction, then count cycles until its done pulse
   task automatic run_op(input logic [7:0] opc, input logic [7:0] unit, input logic [3:0] fn, input logic un,
                         input logic qg, input int hold = 0);
      @(posedge core_clk);
      valid <= 1'b1;
      unlike <= un;
      q_above <= qg;
      instr <= '{opcode: opc, unit: unit, q10: 4'h0, func: fn, p_flag: 1'b1, q_flag: 1'b1};
      @(posedge core_clk);
      valid <= 1'b0;
      // Optional freeze right after the accept; only enabled cycles are counted
      if (hold > 0) begin
         clk_en <= 1'b0;
         repeat (hold) @(posedge core_clk);
         clk_en <= 1'b1;
      end
      #1;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reset, opcode table, then halt and typewriter motion
   initial begin
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      `CHK("ready_after_reset", 1'b1, ready)
      `CHK("busy_after_reset", 1'b0, busy)
      foreach (rows[i]) begin
         run_op(rows[i].opc, UNIT_PRINTER, 4'h0, rows[i].un, rows[i].qg);
         `CHK("op", rows[i].op, dec.op)
         `CHK("quarter_us", rows[i].qus, qus)
         `CHK("interlock", rows[i].qus, n)
      end
      run_op(OPC_HALT, UNIT_PRINTER, 4'h0, 1'b0, 1'b0);
      `CHK("halted", 1'b1, halted)
      `CHK("halt_time", 240, n)
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("halt_holds", 1'b0, ready)
      @(posedge core_clk);
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      #1;
      `CHK("restarted", 1'b0, halted)
      run_op(OPC_CONTROL, UNIT_TYPEWRITER, TYF_RETURN, 1'b0, 1'b0);
      `CHK("return_interlock", 32'hfa0, qus)
      `CHK("motion_busy", 1'b1, type_busy)
      `CHK("motion_refuses", 1'b0, ready)
      run_op(OPC_NOOP, UNIT_PRINTER, 4'h0, 1'b0, 1'b0);
      `CHK("nop_in_motion", 240, n)
      repeat (3800) @(posedge core_clk);
      #1;
      `CHK("motion_over", 1'b0, type_busy)
      // Indirect marks honoured only while the mode is on; enable low freezes the count
      run_op(OPC_OR_FIELD, UNIT_PRINTER, 4'h0, 1'b0, 1'b0);
      `CHK("indirect_on", 2'b11, ({dec.p_indirect, dec.q_indirect}))
      @(posedge core_clk);
      ind_on <= 1'b0;
      flen <= 8'h04;
      run_op(OPC_OR_FIELD, UNIT_PRINTER, 4'h0, 1'b0, 1'b0, 50);
      `CHK("indirect_off", 2'b00, ({dec.p_indirect, dec.q_indirect}))
      `CHK("or_time", 32'h230, qus)
      `CHK("frozen_count", 560, n)
      complete_run();
   end
endmodule
